// *** rtl/ccdc_top.sv ***
// Purpose: channel 2 and 3 divider and output control
// Assumes: mclk is the divider input clock; pins need synchronising
// Notes:   register port is a plain byte write/read strobe pair
module ccdc_top
  import ccdc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              glb_route,
  input  wire logic              chip_sync,
  output logic                   channel2_port_a_en,
  output logic                   channel2_port_b_en,
  output logic                   channel2_port_c_en,
  output logic                   ch2_src_direct,
  output logic                   ch2_duty_cycle_fix_en,
  output logic                   div2_bypass,
  output logic                   div2_out,
  output logic                   div3_bypass,
  output logic                   div3_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic glb_meta_r,  glb_sync_r;
  logic sync_meta_r, sync_sync_r;

  // two flip-flops per pin; only the second stage is read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      glb_meta_r  <= 1'b0;
      glb_sync_r  <= 1'b0;
      sync_meta_r <= 1'b0;
      sync_sync_r <= 1'b0;
    end else begin
      glb_meta_r  <= glb_route;
      glb_sync_r  <= glb_meta_r;
      sync_meta_r <= chip_sync;
      sync_sync_r <= sync_meta_r;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  logic [DATA_W-1:0] div2_cnt_r, div2_cnt_nxt;
  logic [DATA_W-1:0] div2_ctl_r, div2_ctl_nxt;
  logic [DATA_W-1:0] ch2_ctl_r,  ch2_ctl_nxt;
  logic [DATA_W-1:0] div3_cnt_r, div3_cnt_nxt;
  logic [DATA_W-1:0] div3_ctl_r, div3_ctl_nxt;
  logic [DATA_W-1:0] rdata_r,    rdata_nxt;

  // write and read in one cycle: read returns the old byte
  always_comb begin
    div2_cnt_nxt = div2_cnt_r;
    div2_ctl_nxt = div2_ctl_r;
    ch2_ctl_nxt  = ch2_ctl_r;
    div3_cnt_nxt = div3_cnt_r;
    div3_ctl_nxt = div3_ctl_r;
    rdata_nxt    = rdata_r;
    if (reg_wr) begin
      if (ccdc_hit(reg_addr, OFS_DIV2_CNT)) begin
        div2_cnt_nxt = reg_wdata;
      end
      if (ccdc_hit(reg_addr, OFS_DIV2_CTL)) begin
        div2_ctl_nxt = reg_wdata;
      end
      if (ccdc_hit(reg_addr, OFS_CH2_CTL)) begin
        // unused bits of the channel byte stay zero
        ch2_ctl_nxt = reg_wdata & CH_USED_MASK;
      end
      if (ccdc_hit(reg_addr, OFS_DIV3_CNT)) begin
        div3_cnt_nxt = reg_wdata;
      end
      if (ccdc_hit(reg_addr, OFS_DIV3_CTL)) begin
        div3_ctl_nxt = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (ccdc_hit(reg_addr, OFS_DIV2_CNT)) begin
        rdata_nxt = div2_cnt_r;
      end else if (ccdc_hit(reg_addr, OFS_DIV2_CTL)) begin
        rdata_nxt = div2_ctl_r;
      end else if (ccdc_hit(reg_addr, OFS_CH2_CTL)) begin
        rdata_nxt = ch2_ctl_r;
      end else if (ccdc_hit(reg_addr, OFS_DIV3_CNT)) begin
        rdata_nxt = div3_cnt_r;
      end else if (ccdc_hit(reg_addr, OFS_DIV3_CTL)) begin
        rdata_nxt = div3_ctl_r;
      end else begin
        // unmapped offsets read as zero
        rdata_nxt = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div2_cnt_r <= RST_DIV2_CNT;
      div2_ctl_r <= RST_DIV2_CTL;
      ch2_ctl_r  <= RST_CH2_CTL;
      div3_cnt_r <= RST_DIV3_CNT;
      div3_ctl_r <= RST_DIV3_CTL;
      rdata_r    <= RD_UNMAPPED;
    end else begin
      div2_cnt_r <= div2_cnt_nxt;
      div2_ctl_r <= div2_ctl_nxt;
      ch2_ctl_r  <= ch2_ctl_nxt;
      div3_cnt_r <= div3_cnt_nxt;
      div3_ctl_r <= div3_ctl_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // channel 2 output state
  // ****************************************
  logic [CH_PORTS-1:0] port_en_r, port_en_nxt;
  logic                direct_r,  direct_nxt;
  logic                dcc_en_r,  dcc_en_nxt;

  // derived outputs settle one edge after the write
  always_comb begin
    port_en_nxt = {CH_PORTS{!ch2_ctl_r[BIT_CH_PD]}};
    dcc_en_nxt  = !ch2_ctl_r[BIT_CH_DCC];
    direct_nxt  = direct_r;
    // global routing high: direct selection keeps its last value
    if (!glb_sync_r) begin
      direct_nxt = ch2_ctl_r[BIT_CH_DIR];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_en_r <= '0;
      direct_r  <= 1'b0;
      dcc_en_r  <= 1'b0;
    end else begin
      port_en_r <= port_en_nxt;
      direct_r  <= direct_nxt;
      dcc_en_r  <= dcc_en_nxt;
    end
  end

  assign channel2_port_a_en    = port_en_r[0];
  assign channel2_port_b_en    = port_en_r[1];
  assign channel2_port_c_en    = port_en_r[2];
  assign ch2_src_direct        = direct_r;
  assign ch2_duty_cycle_fix_en = dcc_en_r;

  // ****************************************
  // dividers
  // ****************************************
  ccdc_div_if d2 ();
  ccdc_div_if d3 ();

  logic [1:0] byp_r, byp_nxt;
  logic [DATA_W-1:0] div_ctl [2];
  logic [DATA_W-1:0] div_cnt [2];

  assign div_ctl[0] = div2_ctl_r;
  assign div_ctl[1] = div3_ctl_r;
  assign div_cnt[0] = div2_cnt_r;
  assign div_cnt[1] = div3_cnt_r;

  // bypass flag registered so the port comes from a flip-flop
  always_comb begin
    byp_nxt = {div_ctl[1][BIT_BYPASS], div_ctl[0][BIT_BYPASS]};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      byp_r <= 2'h0;
    end else begin
      byp_r <= byp_nxt;
    end
  end

  // settings reach the dividers straight from the registers
  // phase offset bits [3:0] are stored but not used
  assign d2.low_cnt    = div_cnt[0][CNT_LO_MSB:CNT_LO_LSB];
  assign d2.high_cnt   = div_cnt[0][CNT_HI_MSB:CNT_HI_LSB];
  assign d2.bypass     = div_ctl[0][BIT_BYPASS];
  assign d2.ign_sync   = div_ctl[0][BIT_IGN];
  assign d2.force_en   = div_ctl[0][BIT_FORCE];
  assign d2.start_high = div_ctl[0][BIT_START];
  assign d2.sync       = sync_sync_r;

  assign d3.low_cnt    = div_cnt[1][CNT_LO_MSB:CNT_LO_LSB];
  assign d3.high_cnt   = div_cnt[1][CNT_HI_MSB:CNT_HI_LSB];
  assign d3.bypass     = div_ctl[1][BIT_BYPASS];
  assign d3.ign_sync   = div_ctl[1][BIT_IGN];
  assign d3.force_en   = div_ctl[1][BIT_FORCE];
  assign d3.start_high = div_ctl[1][BIT_START];
  assign d3.sync       = sync_sync_r;

  // both dividers share the synchronised chip sync
  ccdc_divider u_div2 (
    .mclk (mclk),
    .rst  (rst),
    .dif  (d2.div)
  );

  ccdc_divider u_div3 (
    .mclk (mclk),
    .rst  (rst),
    .dif  (d3.div)
  );

  assign div2_bypass = byp_r[0];
  assign div3_bypass = byp_r[1];
  assign div2_out    = d2.div_out;
  assign div3_out    = d3.div_out;

endmodule : ccdc_top

// *** pkg/ccdc_pkg.sv ***
// Purpose: constants and types for the channel clock divider control
// Assumes: byte-wide registers at their printed offsets, one clock mclk
// Notes:   shared by the top, the divider and the divider interface
//
// Notes on behaviour
// - bypass bit powers down divider, passes input
// - ignore-sync clear obeys chip sync, set ignores
// - force has no effect while divider bypassed
// - force clear lets divider run, set with ignore-sync set holds start level
// - start-level bit picks high or low start
// - channel 2 power-down idles all three ports
// - direct bit routes input clock to ports
// - global routing bit set freezes channel routing
// - disable bit turns duty-cycle fix off
// - low field is low phase length minus one
// - high field is high phase length minus one
package ccdc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned CH_PORTS = 3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_DIV2_CNT = 10'h196;
  localparam logic [ADDR_W-1:0] OFS_DIV2_CTL = 10'h197;
  localparam logic [ADDR_W-1:0] OFS_CH2_CTL  = 10'h198;
  localparam logic [ADDR_W-1:0] OFS_DIV3_CNT = 10'h199;
  localparam logic [ADDR_W-1:0] OFS_DIV3_CTL = 10'h19A;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [DATA_W-1:0] RST_DIV2_CNT = 8'h11;
  localparam logic [DATA_W-1:0] RST_DIV2_CTL = 8'h00;
  localparam logic [DATA_W-1:0] RST_CH2_CTL  = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIV3_CNT = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIV3_CTL = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED  = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned BIT_BYPASS  = 7;
  localparam int unsigned BIT_IGN     = 6;
  localparam int unsigned BIT_FORCE   = 5;
  localparam int unsigned BIT_START   = 4;
  localparam int unsigned CNT_LO_MSB  = 7;
  localparam int unsigned CNT_LO_LSB  = 4;
  localparam int unsigned CNT_HI_MSB  = 3;
  localparam int unsigned CNT_HI_LSB  = 0;
  localparam int unsigned BIT_CH_PD   = 2;
  localparam int unsigned BIT_CH_DIR  = 1;
  localparam int unsigned BIT_CH_DCC  = 0;
  localparam logic [DATA_W-1:0] CH_USED_MASK = 8'h07;
  localparam logic [CNT_W-1:0]  CNT_ZERO     = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE      = 4'h1;

  // ****************************************
  // divider phase states
  // ****************************************
  typedef enum logic [2:0] {
    CCDC_ST_HOLD = 3'b001,
    CCDC_ST_LOW  = 3'b010,
    CCDC_ST_HIGH = 3'b100
  } ccdc_div_st_t;

  function automatic logic ccdc_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    ccdc_hit = (a == ofs);
  endfunction : ccdc_hit

endpackage : ccdc_pkg

// *** pkg/ccdc_div_if.sv ***
// Purpose: control and result of one channel divider
// Assumes: ccdc_pkg compiled first
// Notes:   ctl side drives settings, div side returns the output
interface ccdc_div_if;
  import ccdc_pkg::*;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] high_cnt;
  logic             bypass;
  logic             ign_sync;
  logic             force_en;
  logic             start_high;
  logic             sync;
  logic             div_out;

  modport ctl (output low_cnt, high_cnt, bypass, ign_sync, force_en, start_high, sync, input div_out);
  modport div (input low_cnt, high_cnt, bypass, ign_sync, force_en, start_high, sync, output div_out);
endinterface : ccdc_div_if

// *** rtl/ccdc_divider.sv ***
// Purpose: low/high cycle divider of one channel
// Assumes: settings and sync already in the mclk domain
// Notes:   output is a flip-flop; driven low while bypassed
module ccdc_divider
  import ccdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  ccdc_div_if.div  dif
);

  ccdc_div_st_t     st_r,  st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             out_r, out_nxt;
  logic             sync_hold;
  logic             forced;

  // ****************************************
  // phase counter
  // ****************************************
  always_comb begin
    sync_hold = dif.sync && !dif.ign_sync;
    forced    = dif.force_en && dif.ign_sync;
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    if (dif.bypass) begin
      st_nxt  = CCDC_ST_HOLD;
      cnt_nxt = CNT_ZERO;
      out_nxt = 1'b0;
    end else if (sync_hold || forced) begin
      st_nxt  = CCDC_ST_HOLD;
      cnt_nxt = CNT_ZERO;
      out_nxt = dif.start_high;
    end else begin
      unique case (st_r)
        CCDC_ST_HOLD: begin
          st_nxt  = dif.start_high ? CCDC_ST_HIGH : CCDC_ST_LOW;
          cnt_nxt = CNT_ZERO;
          out_nxt = dif.start_high;
        end
        CCDC_ST_LOW: begin
          // counting from zero keeps a field of 15 inside four bits
          if (cnt_r >= dif.low_cnt) begin
            st_nxt  = CCDC_ST_HIGH;
            cnt_nxt = CNT_ZERO;
            out_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + CNT_ONE;
          end
        end
        CCDC_ST_HIGH: begin
          if (cnt_r >= dif.high_cnt) begin
            st_nxt  = CCDC_ST_LOW;
            cnt_nxt = CNT_ZERO;
            out_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r + CNT_ONE;
          end
        end
        default: begin
          st_nxt  = CCDC_ST_HOLD;
          cnt_nxt = CNT_ZERO;
          out_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r  <= CCDC_ST_HOLD;
      cnt_r <= CNT_ZERO;
      out_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign dif.div_out = out_r;

endmodule : ccdc_divider

// *** verification/ccdc_checker.sv ***
// Purpose: port checks of the channel divider control
// Assumes: ccdc_pkg compiled first
// Notes:   bound into ccdc_top below
module ccdc_checker
  import ccdc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              glb_route,
  input wire logic              chip_sync,
  input wire logic              channel2_port_a_en,
  input wire logic              channel2_port_b_en,
  input wire logic              channel2_port_c_en,
  input wire logic              ch2_src_direct,
  input wire logic              ch2_duty_cycle_fix_en,
  input wire logic              div3_bypass,
  input wire logic              div3_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************************************
  // divider 3 shadow and phase timing
  // ****************************************
  logic [DATA_W-1:0] cnt3_r, ctl3_r;
  logic [5:0]        quiet_r, run_r;
  logic              prev_r;
  wire logic w198  = reg_wr && reg_addr == OFS_CH2_CTL;
  wire logic w19a  = reg_wr && reg_addr == OFS_DIV3_CTL;
  wire logic free3 = ctl3_r[7:5] == 3'b010 && quiet_r > run_r + 6'h04;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt3_r  <= RST_DIV3_CNT;
      ctl3_r  <= RST_DIV3_CTL;
      quiet_r <= 6'h00;
      run_r   <= 6'h00;
      prev_r  <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_DIV3_CNT) cnt3_r <= reg_wdata;
      if (w19a) ctl3_r <= reg_wdata;
      quiet_r <= reg_wr ? 6'h00 : quiet_r + {5'h00, quiet_r != 6'h3F};
      run_r   <= (div3_out != prev_r) ? 6'h00 : run_r + {5'h00, run_r != 6'h3F};
      prev_r  <= div3_out;
    end
  end
  port_power_a: assert property (w198 ##1 !w198 |-> ##1 {channel2_port_a_en, channel2_port_b_en,
    channel2_port_c_en} == {3{!$past(reg_wdata[2], 2)}}) else $error("port enables wrong");
  dcc_follow_a: assert property (w198 ##1 !w198 |-> ##1 ch2_duty_cycle_fix_en == !$past(reg_wdata[0], 2))
    else $error("duty fix enable wrong");
  direct_route_a: assert property (!glb_route[*4] ##0 w198 ##1 (!w198 && !glb_route)
    |-> ##1 ch2_src_direct == $past(reg_wdata[1], 2)) else $error("direct routing wrong");
  route_freeze_a: assert property (glb_route[*6] |-> $stable(ch2_src_direct))
    else $error("routing moved while frozen");
  bypass_flag_a: assert property (w19a ##1 !w19a |-> ##1 div3_bypass == $past(reg_wdata[7], 2))
    else $error("bypass flag wrong");
  bypass_out_a: assert property (div3_bypass && $past(div3_bypass) |-> !div3_out)
    else $error("output moved while bypassed");
  sync_hold_a: assert property (chip_sync[*5] ##0 (ctl3_r[7:6] == 2'b00 && quiet_r > 6'h05)
    |-> div3_out == ctl3_r[4]) else $error("sync did not hold start level");
  force_level_a: assert property (ctl3_r[7:5] == 3'b011 && quiet_r > 6'h03 |-> div3_out == ctl3_r[4])
    else $error("forced level wrong");
  phase_len_a: assert property (free3 && div3_out != prev_r
    |-> run_r == (div3_out ? {2'b00, cnt3_r[7:4]} : {2'b00, cnt3_r[3:0]})) else $error("phase length wrong");
  cover property (w198 && reg_wdata[2]);
  cover property (free3 && div3_out != prev_r);
  cover property (glb_route[*6]);
endmodule : ccdc_checker

bind ccdc_top ccdc_checker chk_u (.*);

// *** verification/test_ccdc_top.sv ***
// Purpose: directed test of the channel divider control
// Assumes: ccdc_pkg compiled first
// Notes:   inputs change on the falling edge of mclk
module test_ccdc_top
  import ccdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 10'h000;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              glb_route = 1'b0;
  logic              chip_sync = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              channel2_port_a_en, channel2_port_b_en, channel2_port_c_en, ch2_src_direct;
  logic              ch2_duty_cycle_fix_en, div2_bypass, div2_out, div3_bypass, div3_out;
  logic [7:0]        cnt_tab [4] = '{8'h21, 8'hF0, 8'h0F, 8'hFF};
  int                err_total = 0;
  int                n_checks = 0;
  wire logic [7:0]   st = {ch2_duty_cycle_fix_en, ch2_src_direct, div2_bypass, div3_bypass, 1'b0,
                           channel2_port_a_en, channel2_port_b_en, channel2_port_c_en};

  ccdc_top dut_u (.*);
  initial forever #25 mclk = ~mclk;
  // ****************************************
  // access and measurement tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic per(input logic c, input logic [3:0] lo, input logic [3:0] hi);
    int n[4];
    for (int i = 0; i < 4; i++) begin
      n[i] = 0;
      while ((c ? div2_out : div3_out) === !i[0] && n[i] < 40) begin
        @(negedge mclk);
        n[i]++;
      end
    end
    chk("high phase", 8'(hi) + 8'h01, 8'(n[2]));
    chk("low phase", 8'(lo) + 8'h01, 8'(n[3]));
  endtask : per
  task automatic hold(input logic lvl);
    repeat (2) begin
      repeat (17) @(negedge mclk);
      chk("div3_out", {7'h00, lvl}, {7'h00, div3_out});
    end
  endtask : hold
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    rd(OFS_DIV2_CNT, 8'h11);
    rd(OFS_DIV2_CTL, 8'h00);
    rd(OFS_CH2_CTL, 8'h00);
    rd(OFS_DIV3_CNT, 8'h00);
    rd(OFS_DIV3_CTL, 8'h00);
    chk("state", 8'h87, st);
    per(1'b1, 4'h1, 4'h1);
    per(1'b0, 4'h0, 4'h0);
    wr(10'h1E0, 8'hFF);
    rd(10'h1E0, 8'h00);
    wr(OFS_CH2_CTL, 8'hFF);
    rd(OFS_CH2_CTL, 8'h07);
    chk("state", 8'h40, st);
    wr(OFS_CH2_CTL, 8'h00);
    glb_route = 1'b1;
    repeat (6) @(negedge mclk);
    wr(OFS_CH2_CTL, 8'h02);
    chk("state", 8'h87, st);
    glb_route = 1'b0;
    repeat (6) @(negedge mclk);
    chk("state", 8'hC7, st);
    wr(OFS_CH2_CTL, 8'h00);
    wr(OFS_DIV3_CTL, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DIV3_CNT, cnt_tab[i]);
      rd(OFS_DIV3_CNT, cnt_tab[i]);
      per(1'b0, cnt_tab[i][7:4], cnt_tab[i][3:0]);
    end
    wr(OFS_DIV3_CTL, 8'h30);
    per(1'b0, 4'hF, 4'hF);
    wr(OFS_DIV3_CTL, 8'h70);
    hold(1'b1);
    wr(OFS_DIV3_CTL, 8'h60);
    hold(1'b0);
    chip_sync = 1'b1;
    wr(OFS_DIV3_CTL, 8'h10);
    hold(1'b1);
    wr(OFS_DIV3_CTL, 8'h50);
    per(1'b0, 4'hF, 4'hF);
    wr(OFS_DIV3_CTL, 8'h00);
    hold(1'b0);
    chip_sync = 1'b0;
    wr(OFS_DIV3_CTL, 8'hF0);
    hold(1'b0);
    wr(OFS_DIV2_CTL, 8'h80);
    chk("state", 8'hB7, st);
    wr(OFS_DIV2_CTL, 8'h00);
    per(1'b1, 4'h1, 4'h1);
    end_of_test();
  end
endmodule : test_ccdc_top
